// ==== adc_timing_control.v ====
// timing configuration register of the converter with AHB-Lite slave
// assumes a single AHB-Lite master on I_CORE_CLK; rc tick is async pin
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "adc_timing_defs.vh"
// Notes on behaviour
// - source bit picks RC or instruction clock
// - sample time is field times periods
// - period is divider plus one instruction cycles; the RC tick is not divided
// - implemented bits reset zero, read/write
module adc_timing_control (
    input wire I_CORE_CLK,
    input wire I_SYS_RST,
    input wire I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [2:0] I_HSIZE,
    input wire [31:0] I_HWDATA,
    input wire I_HREADY,
    input wire I_RC_OSC,
    input wire I_SAMPLE_START,
    output reg [31:0] O_HRDATA,
    output wire O_HREADYOUT,
    output wire O_HRESP,
    output wire O_CONV_TICK,
    output wire O_SAMPLING,
    output wire O_SAMPLE_DONE
);
    // fixed layout of the one configuration word
    localparam [15:0] CFG_RST = `TIMING_CONFIG_RESET;
    localparam [15:0] CFG_MASK = `WRITE_MASK;

    // configuration word as seen by the timing logic
    wire [15:0] timing_cfg;

    // fields of the configuration word
    wire src_sel;
    wire [4:0] sample_time;
    wire [7:0] divider;

    // bus side state and decode
    reg wr_pend_r;
    reg cfg_hit;
    reg stat_hit;
    reg [31:0] rdata_nxt;
    wire [15:0] cfg_view;
    wire take;
    wire cfg_wr_en;

    // rc pin synchroniser and edge detector
    reg rc_s1_r;
    reg rc_s2_r;
    reg rc_s3_r;
    wire rc_tick;

    // sample request edge detector
    reg start_d_r;
    wire start_pulse;

    // zero wait states: every transfer ends in its first data cycle
    assign O_HREADYOUT = 1'b1;

    // nothing is refused, so the response never leaves okay
    assign O_HRESP = `HRESP_OKAY;

    // a transfer is taken only when selected, ready and non-sequential;
    // idle and busy cycles fall through without any side effect
    assign take = I_HSEL && I_HREADY && (I_HTRANS == `HTRANS_NONSEQ);

    // address decode of the two word offsets; all else is unmapped
    always @*
    begin
        cfg_hit = 1'b0;
        stat_hit = 1'b0;
        if (I_HADDR == `ADDR_TIMING_CONFIG)
            cfg_hit = 1'b1;
        else if (I_HADDR == `ADDR_TIMING_STATUS)
            stat_hit = 1'b1;
    end

    // write data arrives one cycle after its address, so only the hit
    // on the configuration word is carried into the data phase; the
    // status word is read-only and writes to it are dropped here
    always @(posedge I_CORE_CLK)
    begin
        if (I_SYS_RST)
            wr_pend_r <= 1'b0;
        else
            wr_pend_r <= take && I_HWRITE && cfg_hit;
    end

    // the write lands at the end of the data phase
    assign cfg_wr_en = wr_pend_r;

    // one flop per implemented bit; holes in the mask stay constant,
    // so no write pattern can ever set them
    genvar b;
    generate
        for (b = 0; b < 16; b = b + 1)
        begin : g_cfg_bit
            if (CFG_MASK[b])
            begin : g_impl
                reg bit_r;
                always @(posedge I_CORE_CLK)
                begin
                    if (I_SYS_RST)
                        bit_r <= CFG_RST[b];
                    else if (cfg_wr_en)
                        bit_r <= I_HWDATA[b];
                end
                assign timing_cfg[b] = bit_r;
            end
            else
            begin : g_hole
                assign timing_cfg[b] = 1'b0;
            end
        end
    endgenerate

    assign src_sel = timing_cfg[`FIELD_SRC_BIT];

    assign sample_time = timing_cfg[`FIELD_SAMPLE_HI:`FIELD_SAMPLE_LO];

    // divider field, period is code plus one
    assign divider = timing_cfg[`FIELD_DIV_HI:`FIELD_DIV_LO];

    // a read whose address phase meets a write's data phase must see the
    // new word; without this a write and read back to back read stale
    assign cfg_view = cfg_wr_en ? (I_HWDATA[15:0] & CFG_MASK) : timing_cfg;

    // read data mux; unmapped offsets read as zero
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        if (cfg_hit)
            rdata_nxt = {16'h0000, cfg_view};
        else if (stat_hit)
            rdata_nxt = {30'h0000_0000, O_SAMPLING, O_CONV_TICK};
    end

    // read data is launched at the end of the address phase and stands
    // through the data phase until the next read is taken; the status
    // bits are a snapshot and may be stale by the time they are used
    always @(posedge I_CORE_CLK)
    begin
        if (I_SYS_RST)
            O_HRDATA <= 32'h0000_0000;
        else if (take && !I_HWRITE)
            O_HRDATA <= rdata_nxt;
    end

    // rc oscillator pin is asynchronous: two flops, then edge detect;
    // only the second flop feeds logic, the first may be metastable
    always @(posedge I_CORE_CLK)
    begin
        if (I_SYS_RST)
        begin
            rc_s1_r <= 1'b0;
            rc_s2_r <= 1'b0;
            rc_s3_r <= 1'b0;
        end
        else
        begin
            rc_s1_r <= I_RC_OSC;
            rc_s2_r <= rc_s1_r;
            rc_s3_r <= rc_s2_r;
        end
    end

    // one tick per rising edge of the oscillator; the pin idles low, as
    // the flops do after reset, so no false edge follows reset
    assign rc_tick = rc_s2_r && !rc_s3_r;

    // a start held high opens one window only; a level would retrigger
    // back to back windows when the sample time is non-zero
    always @(posedge I_CORE_CLK)
    begin
        if (I_SYS_RST)
            start_d_r <= 1'b0;
        else
            start_d_r <= I_SAMPLE_START;
    end

    // start request qualified to its first cycle
    assign start_pulse = I_SAMPLE_START && !start_d_r;

    conv_clock_gen u_gen (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SYS_RST),
        .i_use_rc(src_sel),
        .i_rc_tick(rc_tick),
        .i_divider(divider),
        .i_sample_time(sample_time),
        .i_sample_start(start_pulse),
        .o_period_tick(O_CONV_TICK),
        .o_sampling(O_SAMPLING),
        .o_sample_done(O_SAMPLE_DONE)
    );

    // limitation: a divider change takes effect at once against the running
    // count, so the first period after a write may be of neither length;
    // reserved divider codes are not refused and simply divide further
endmodule // adc_timing_control
`default_nettype wire

// ==== adc_timing_defs.vh ====
// constants for the converter timing configuration block
// assumes a 20 MHz core clock; one instruction cycle is one core clock
`ifndef ADC_TIMING_DEFS_VH
`define ADC_TIMING_DEFS_VH
`define ADDR_TIMING_CONFIG 32'h0000_0000
`define ADDR_TIMING_STATUS 32'h0000_0004
`define TIMING_CONFIG_RESET 16'h0000
`define FIELD_SRC_BIT 15
`define FIELD_SAMPLE_HI 12
`define FIELD_SAMPLE_LO 8
`define FIELD_DIV_HI 7
`define FIELD_DIV_LO 0
`define WRITE_MASK 16'h9FFF
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0
`endif

// ==== conv_clock_gen.v ====
// conversion clock tick generator and auto-sample period counter
// assumes the enable pulses all live on the one core clock
`timescale 1ns/10ps
`default_nettype none
module conv_clock_gen (
    input wire i_clk,
    input wire i_rst,
    input wire i_use_rc,
    input wire i_rc_tick,
    input wire [7:0] i_divider,
    input wire [4:0] i_sample_time,
    input wire i_sample_start,
    output reg o_period_tick,
    output reg o_sampling,
    output reg o_sample_done
);
    reg [7:0] div_cnt_r;
    reg [4:0] samp_cnt_r;
    wire cyc_tick;

    // divide the instruction cycle by divider plus one
    assign cyc_tick = (div_cnt_r >= i_divider);

    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            div_cnt_r <= 8'h00;
            o_period_tick <= 1'b0;
        end
        else
        begin
            if (cyc_tick)
                div_cnt_r <= 8'h00;
            else
                div_cnt_r <= div_cnt_r + 8'h01;
            o_period_tick <= i_use_rc ? i_rc_tick : cyc_tick;
        end
    end

    // sample window of sample_time conversion periods; zero ends at once
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            samp_cnt_r <= 5'h00;
            o_sampling <= 1'b0;
            o_sample_done <= 1'b0;
        end
        else
        begin
            o_sample_done <= 1'b0;
            if (i_sample_start && !o_sampling)
            begin
                if (i_sample_time == 5'h00)
                    o_sample_done <= 1'b1;
                else
                begin
                    o_sampling <= 1'b1;
                    samp_cnt_r <= i_sample_time;
                end
            end
            else if (o_sampling && o_period_tick)
            begin
                if (samp_cnt_r == 5'h01)
                begin
                    o_sampling <= 1'b0;
                    o_sample_done <= 1'b1;
                end
                samp_cnt_r <= samp_cnt_r - 5'h01;
            end
        end
    end
endmodule // conv_clock_gen
`default_nettype wire

// ==== adc_timing_control_assertions.sv ====
// port checker for the converter timing block
// assumes binding onto adc_timing_control, one clock domain
`timescale 1ns/10ps
`default_nettype none
module adc_timing_chk (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_CONV_TICK,
    input wire logic O_SAMPLING,
    input wire logic O_SAMPLE_DONE
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);
    property p_gap; O_HRDATA[14:13] == 2'h0; endproperty
    a_gap: assert property (p_gap) else $error("gap bits set");
    // reset must win, so this one is not disabled by it
    property p_rst;
        disable iff (1'b0) I_SYS_RST |=> O_HRDATA == 32'h0 && !O_SAMPLING;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    // slowest legal period is 256 cycles, rc pin gives 16
    property p_tick; O_CONV_TICK |-> ##[1:256] O_CONV_TICK; endproperty
    a_tick: assert property (p_tick) else $error("tick lost");
    property p_end; $fell(O_SAMPLING) |-> O_SAMPLE_DONE; endproperty
    a_end: assert property (p_end) else $error("no done");
    property p_pulse; O_SAMPLE_DONE |=> !O_SAMPLE_DONE; endproperty
    a_pulse: assert property (p_pulse) else $error("done stuck");
    c_smp: cover property ($rose(O_SAMPLING));
    c_done: cover property (O_SAMPLE_DONE);
    c_tick: cover property (O_CONV_TICK ##1 !O_CONV_TICK);
endmodule // adc_timing_chk
bind adc_timing_control adc_timing_chk u_chk (.I_CORE_CLK, .I_SYS_RST,
    .O_HRDATA, .O_CONV_TICK, .O_SAMPLING, .O_SAMPLE_DONE);
`default_nettype wire

// ==== adc_timing_control_tb.sv ====
// self-checking bench for the converter timing block
// assumes design files and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "adc_timing_defs.vh"
module adc_timing_control_tb;
    logic clk = 0, rst = 1, sel = 0, wr = 0, osc = 0, st = 0;
    logic [1:0] tr = 0;
    logic [2:0] oc = 0;
    logic [31:0] ad = 0, wd = 0, rd;
    logic rdy, resp, tk, smp, dn;
    int err_total = 0, total_checks = 0, n;
    adc_timing_control dut (.I_CORE_CLK(clk), .I_SYS_RST(rst),
        .I_HSEL(sel), .I_HADDR(ad), .I_HTRANS(tr), .I_HWRITE(wr),
        .I_HSIZE(3'h2), .I_HWDATA(wd), .I_HREADY(rdy), .I_RC_OSC(osc),
        .I_SAMPLE_START(st), .O_HRDATA(rd), .O_HREADYOUT(rdy),
        .O_HRESP(resp), .O_CONV_TICK(tk), .O_SAMPLING(smp),
        .O_SAMPLE_DONE(dn));
    initial forever #25 clk = ~clk;
    // rc pin toggles every 8 cycles, so a 16 cycle period
    always @(posedge clk)
    begin
        oc <= oc + 3'h1;
        if (oc == 3'h7) osc <= ~osc;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // idle cycle first: transfers never overlap, so the write bypass is not exercised
    task bus(input logic w, input logic [31:0] a, d, exp);
    begin
        @(posedge clk);
        sel <= 1; tr <= `HTRANS_NONSEQ; wr <= w; ad <= a;
        @(posedge clk); while (!rdy) @(posedge clk);
        sel <= 0; tr <= 2'h0; wd <= d;
        @(posedge clk); while (!rdy) @(posedge clk);
        if (!w) chk(rd, exp);
        chk(resp, `HRESP_OKAY);
    end
    endtask
    task per(input logic [31:0] exp);
    begin
        // skip two ticks: the first after a source or divider change may be short
        @(negedge clk); while (!tk) @(negedge clk);
        @(negedge clk); while (!tk) @(negedge clk);
        @(negedge clk); n = 1;
        while (!tk) begin @(negedge clk); n++; end
        chk(n, exp);
    end
    endtask
    task samp(input logic [4:0] s);
    begin
        bus(1, `ADDR_TIMING_CONFIG, {s, 8'h00}, 0);
        st <= 1; @(posedge clk); st <= 0;
        n = 0; @(negedge clk);
        while (smp) begin n++; @(negedge clk); end
        chk(n, {27'h0, s});
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end
    endtask
    initial begin #200000; err_total++; end_sim; end
    initial
    begin
        repeat (3) @(posedge clk); rst <= 0;
        bus(0, `ADDR_TIMING_CONFIG, 0, `TIMING_CONFIG_RESET);
        bus(1, `ADDR_TIMING_CONFIG, 32'hFFFF_FF3F, 0);
        bus(0, `ADDR_TIMING_CONFIG, 0, 32'h0000_9F3F);
        per(16);
        bus(1, 32'h0000_0010, 32'h0000_1234, 0);
        bus(0, 32'h0000_0010, 0, 0);
        bus(1, `ADDR_TIMING_CONFIG, 32'h0000_0003, 0); per(4);
        bus(1, `ADDR_TIMING_CONFIG, 32'h0000_003F, 0); per(64);
        bus(1, `ADDR_TIMING_CONFIG, 32'h0000_0000, 0); per(1);
        samp(5'h01); samp(5'h1F);
        samp(5'h00);
        end_sim;
    end
endmodule // adc_timing_control_tb
`default_nettype wire
